// ===== bench/bfp_fault_top_assertions.sv
// checker: timing relations at the fault block ports
`timescale 1ns/1ps
module bfp_fault_checker
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pwm_high_in,
  input wire logic pwm_low_in,
  input wire logic over_temp_in,
  input wire logic code_protect_bit,
  input wire logic ext_prog_rd_req,
  input wire logic ext_prog_wr_req,
  input wire logic high_gate_out,
  input wire logic low_gate_out,
  input wire logic phase_float,
  input wire logic thermal_shutdown,
  input wire logic prog_rd_en,
  input wire logic prog_wr_en
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_high_from_pwm: assert property (high_gate_out |-> $past(pwm_high_in))
    else $error("high gate on without request");
  a_low_from_pwm: assert property (low_gate_out |-> $past(pwm_low_in))
    else $error("low gate on without request");
  a_float_gates_low: assert property (phase_float |-> !high_gate_out && !low_gate_out)
    else $error("gate driven while phase floats");
  a_hot_gates_low: assert property (thermal_shutdown |-> !high_gate_out && !low_gate_out)
    else $error("gate driven while hot");
  a_hot_follows_pin: assert property (thermal_shutdown |-> $past(over_temp_in, 3))
    else $error("shutdown without hot pin");
  a_read_protect: assert property (prog_rd_en |->
      !$past(code_protect_bit, 2) && $past(ext_prog_rd_req, 3))
    else $error("program read while protected");
  a_write_protect: assert property (prog_wr_en |->
      !$past(code_protect_bit, 2) && $past(ext_prog_wr_req, 3))
    else $error("program write while protected");
  a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("bus answer not one cycle after setup");
endmodule // bfp_fault_checker

bind bfp_fault_top bfp_fault_checker u_chk (.pclk, .presetn, .psel, .penable, .pready,
  .pwm_high_in, .pwm_low_in, .over_temp_in, .code_protect_bit, .ext_prog_rd_req,
  .ext_prog_wr_req, .high_gate_out, .low_gate_out, .phase_float, .thermal_shutdown,
  .prog_rd_en, .prog_wr_en);

// ===== bench/bfp_switch_model.sv
// model of the external power switch pair driven by the gate outputs
`timescale 1ns/1ps
module bfp_switch_model
  import bfp_pkg::*;
(
  input  wire logic               high_gate_out,
  input  wire logic               low_gate_out,
  input  wire logic               phase_float,
  input  wire logic [SENSE_W-1:0] load_code,
  output logic      [SENSE_W-1:0] hs_vds_code
);
  // open high side sees the whole input: drop reads full scale, never a kind zero
  assign hs_vds_code = (high_gate_out && !phase_float && !low_gate_out) ? load_code : 8'hFF;
endmodule // bfp_switch_model

// ===== bench/test_buck_fault_protection_gating.sv
// self-checking bench for the buck fault protection block
`timescale 1ns/1ps
module test_buck_fault_protection_gating;
  import bfp_pkg::*;
  typedef struct packed { logic [7:0] a; logic [31:0] m; } bfp_row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, vin_code, vout_code, hs_vds_code, load_code;
  logic [31:0] pwdata, prdata, rd;
  logic        pwm_high_in, pwm_low_in, over_temp_in, code_protect_bit;
  logic        ext_prog_rd_req, ext_prog_wr_req, high_gate_out, low_gate_out;
  logic        phase_float, pull_up_setting, thermal_shutdown, prog_rd_en, prog_wr_en;
  logic [6:0]  primary_bus_address, alert_address;
  int          n_mismatch, total_checks, cyc;
  int          leb [4];
  bfp_row_t    rows [10];

  bfp_fault_top DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .vin_code, .vout_code, .hs_vds_code, .pwm_high_in, .pwm_low_in,
    .over_temp_in, .code_protect_bit, .ext_prog_rd_req, .ext_prog_wr_req, .high_gate_out,
    .low_gate_out, .phase_float, .pull_up_setting, .thermal_shutdown, .prog_rd_en,
    .prog_wr_en, .primary_bus_address, .alert_address);
  bfp_switch_model u_sw (.high_gate_out, .low_gate_out, .phase_float, .load_code,
    .hs_vds_code);

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic test_done();
    if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ceiling far above the few hundred cycles the sequence needs
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(a, 1'b0, 32'h0);
    chk(nm, rd, e);
  endtask

  task automatic gchk(input logic [1:0] e);
    chk("gates", 32'({high_gate_out, low_gate_out}), 32'(e));
  endtask

  task automatic drv(input logic [2:0] t, input logic [1:0] p, input logic [1:0] e);
    pwm_high_in <= p[1];
    pwm_low_in <= p[0];
    wr(ADDR_DRV_TEST, 32'(t));
    tick(2);
    gchk(e);
    chk("float", 32'(phase_float), 32'(t[0]));
  endtask

  // threshold written before the enable so no stale compare trips early
  task automatic trip(input logic [1:0] en, input logic [7:0] ta, input logic [7:0] thr,
                      input logic [7:0] bad, input logic [31:0] m);
    wr(ta, 32'(thr));
    vout_code <= thr;
    wr(ADDR_ABE, 32'(en));
    wr(ADDR_DRV_OPT, 32'(en));
    tick(3);
    gchk(2'b10);
    vout_code <= bad;
    tick(3);
    gchk(2'b00);
    vout_code <= thr;
    tick(3);
    gchk(2'b00);
    rdc(ADDR_FLAGS, m, "fault flag");
    wr(ADDR_FLAGS, m);
    tick(2);
    gchk(2'b10);
    wr(ADDR_ABE, 32'h0);
    wr(ADDR_DRV_OPT, 32'h0);
  endtask

  task automatic pulse(input int n);
    pwm_high_in <= 1'b1;
    tick(n);
    pwm_high_in <= 1'b0;
    tick(3);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    vin_code = 8'hFF;
    vout_code = 8'h80;
    load_code = 8'h10;
    pwm_high_in = 1'b0;
    pwm_low_in = 1'b0;
    over_temp_in = 1'b0;
    code_protect_bit = 1'b1;
    ext_prog_rd_req = 1'b0;
    ext_prog_wr_req = 1'b0;
    n_mismatch = 0;
    total_checks = 0;
    cyc = 0;
    leb = '{LEB_CYC_0, LEB_CYC_1, LEB_CYC_2, LEB_CYC_3};
    rows = '{'{ADDR_VIN_LVL, 32'h1FF}, '{ADDR_OC_CTRL, 32'h7FF}, '{ADDR_ABE, 32'h3},
             '{ADDR_UV_THR, 32'hFF}, '{ADDR_OV_THR, 32'hFF}, '{ADDR_DRV_OPT, 32'h7},
             '{ADDR_DRV_TEST, 32'h7}, '{ADDR_BUS_ADDR, 32'h7F}, '{ADDR_ALERT, 32'h7F},
             '{ADDR_IRQ_CTRL, 32'h3F}};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    tick(1);
    chk("alert reset", 32'(alert_address), 32'h0C);
    chk("bus reset", 32'(primary_bus_address), 32'h0);
    gchk(2'b00);
    rdc(ADDR_ALERT, 32'h0C, "alert reg");
    foreach (rows[i]) begin
      wr(rows[i].a, 32'hFFFF_FFFF);
      rdc(rows[i].a, rows[i].m, "reg ones");
      wr(rows[i].a, 32'h0);
      rdc(rows[i].a, 32'h0, "reg zero");
    end
    apb(8'h30, 1'b0, 32'h0);
    chk("unmapped err", 32'(err), 32'h1);
    chk("unmapped data", rd, 32'h0);
    wr(ADDR_BUS_ADDR, 32'h2A);
    wr(ADDR_ALERT, 32'h33);
    wr(ADDR_DRV_OPT, 32'h4);
    tick(2);
    chk("bus addr", 32'(primary_bus_address), 32'h2A);
    chk("alert addr", 32'(alert_address), 32'h33);
    chk("pull up", 32'(pull_up_setting), 32'h1);
    wr(ADDR_DRV_OPT, 32'h0);
    wr(ADDR_FLAGS, 32'h1F);
    drv(3'h0, 2'b10, 2'b10);
    drv(3'h2, 2'b10, 2'b00);
    drv(3'h2, 2'b01, 2'b01);
    drv(3'h4, 2'b01, 2'b00);
    drv(3'h1, 2'b10, 2'b00);
    drv(3'h0, 2'b10, 2'b10);
    // all interrupt enables clear: flags must still rise
    wr(ADDR_VIN_LVL, 32'h180);
    vin_code <= 8'h7F;
    tick(3);
    rdc(ADDR_FLAGS, 32'h1, "vin low");
    rdc(ADDR_STATUS, 32'h1, "vin live");
    wr(ADDR_DRV_TEST, 32'h1);
    tick(2);
    gchk(2'b00);
    wr(ADDR_DRV_TEST, 32'h0);
    vin_code <= 8'h80;
    tick(3);
    rdc(ADDR_FLAGS, 32'h0, "vin back");
    vin_code <= 8'hFF;
    trip(2'b01, ADDR_UV_THR, 8'h40, 8'h3F, 32'h4);
    trip(2'b10, ADDR_OV_THR, 8'hC0, 8'hC1, 32'h8);
    pwm_high_in <= 1'b0;
    load_code <= 8'h30;
    tick(3);
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_OC_CTRL, 32'h420 | 32'(s << 8));
      pulse(leb[s]);
      rdc(ADDR_FLAGS, 32'h0, "oc blanked");
      pulse(leb[s] + 2);
      rdc(ADDR_FLAGS, 32'h2, "oc seen");
      wr(ADDR_FLAGS, 32'h2);
    end
    wr(ADDR_OC_CTRL, 32'h0);
    pwm_high_in <= 1'b1;
    over_temp_in <= 1'b1;
    tick(4);
    chk("shutdown", 32'(thermal_shutdown), 32'h1);
    gchk(2'b00);
    over_temp_in <= 1'b0;
    tick(4);
    gchk(2'b10);
    rdc(ADDR_FLAGS, 32'h10, "hot flag");
    ext_prog_rd_req <= 1'b1;
    ext_prog_wr_req <= 1'b1;
    tick(5);
    chk("prog locked", 32'({prog_rd_en, prog_wr_en}), 32'h0);
    code_protect_bit <= 1'b0;
    tick(5);
    chk("prog open", 32'({prog_rd_en, prog_wr_en}), 32'h3);
    // mid-run reset: defaults back, gates low, then normal drive again
    presetn <= 1'b0;
    tick(2);
    chk("rst alert", 32'(alert_address), 32'h0C);
    chk("rst bus", 32'(primary_bus_address), 32'h0);
    chk("rst out", 32'({high_gate_out, low_gate_out, prog_rd_en, thermal_shutdown}), 32'h0);
    presetn <= 1'b1;
    tick(4);
    gchk(2'b10);
    rdc(ADDR_FLAGS, 32'h0, "flags after reset");
    test_done();
  end
endmodule // test_buck_fault_protection_gating

// ===== verilog/bfp_fault_top.sv
// top: fault detection, gate drive forcing and APB registers of the buck controller
//
// Notes on behaviour
// RL1 - input undervoltage flag set below level
// RL2 - input undervoltage flag self-clears above level
// RL3 - firmware enables input undervoltage comparison first
// RL4 - flags set regardless of interrupt enables
// RL5 - overcurrent compared only while high side conducts; code uses pwm_high_in, also comparing while the high gate is forced low
// RL6 - overcurrent blanked after turn-on, two-bit length
// RL7 - firmware sets overcurrent enable for detection
// RL8 - output undervoltage flag when enabled and below
// RL9 - firmware clears output undervoltage flag
// RL10 - undervoltage trip holds both gates low
// RL11 - output overvoltage flag when enabled and above
// RL12 - firmware clears output overvoltage flag
// RL13 - overvoltage trip holds both gates low
// RL14 - hardware overtemperature shutdown, no firmware needed
// RL15 - code protection blocks external program access
// RL16 - bus address from primary address register
// RL17 - second 7-bit alert address register
// RL18 - firmware advised to stop switching on undervoltage
// RL19 - global disable forces gates low, phase floats
// RL20 - per-side disable forces that gate low
// RL21 - gates are pwm ANDed with no forcing
`timescale 1ns/1ps
module bfp_fault_top
  import bfp_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic [APB_AW-1:0]  paddr,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [SENSE_W-1:0] vin_code,
  input  wire logic [SENSE_W-1:0] vout_code,
  input  wire logic [SENSE_W-1:0] hs_vds_code,
  input  wire logic               pwm_high_in,
  input  wire logic               pwm_low_in,
  input  wire logic               over_temp_in,
  input  wire logic               code_protect_bit,
  input  wire logic               ext_prog_rd_req,
  input  wire logic               ext_prog_wr_req,
  output logic                    high_gate_out,
  output logic                    low_gate_out,
  output logic                    phase_float,
  output logic                    pull_up_setting,
  output logic                    thermal_shutdown,
  output logic                    prog_rd_en,
  output logic                    prog_wr_en,
  output logic      [ADDR_W-1:0]  primary_bus_address,
  output logic      [ADDR_W-1:0]  alert_address
);

  // register state
  bfp_vin_lvl_t      vin_lvl_r;
  bfp_vin_lvl_t      vin_lvl_nxt;
  bfp_oc_ctrl_t      oc_ctrl_r;
  bfp_oc_ctrl_t      oc_ctrl_nxt;
  bfp_abe_t          abe_r;
  bfp_abe_t          abe_nxt;
  logic [SENSE_W-1:0] uv_thr_r;
  logic [SENSE_W-1:0] uv_thr_nxt;
  logic [SENSE_W-1:0] ov_thr_r;
  logic [SENSE_W-1:0] ov_thr_nxt;
  bfp_flags_t        flags_r;
  bfp_flags_t        flags_nxt;
  bfp_drv_opt_t      drv_opt_r;
  bfp_drv_opt_t      drv_opt_nxt;
  bfp_drv_test_t     drv_test_r;
  bfp_drv_test_t     drv_test_nxt;
  bfp_irq_ctrl_t     irq_ctrl_r;
  bfp_irq_ctrl_t     irq_ctrl_nxt;
  logic [ADDR_W-1:0] bus_addr_r;
  logic [ADDR_W-1:0] bus_addr_nxt;
  logic [ADDR_W-1:0] alert_addr_r;
  logic [ADDR_W-1:0] alert_addr_nxt;

  // apb answer
  logic [31:0]       prdata_r;
  logic [31:0]       prdata_nxt;
  logic              pready_r;
  logic              pready_nxt;
  logic              pslverr_r;
  logic              pslverr_nxt;

  // pin synchronisers: stage 1 is read only by stage 2
  // over temp and program requests arrive with no clock relation
  logic [2:0]        sync1_r;
  logic [2:0]        sync2_r;
  logic [2:0]        pin_raw;

  // gate and access outputs
  logic              high_gate_r;
  logic              high_gate_nxt;
  logic              low_gate_r;
  logic              low_gate_nxt;
  logic              phase_float_r;
  logic              phase_float_nxt;
  logic              tsd_r;
  logic              tsd_nxt;
  logic              prog_rd_r;
  logic              prog_rd_nxt;
  logic              prog_wr_r;
  logic              prog_wr_nxt;
  logic              cp_r;
  logic              cp_nxt;

  logic              setup;
  logic              access;
  logic              wr;
  logic              hit;
  logic [31:0]       rd_val;
  bfp_flags_t        w1c;
  bfp_flags_t        set;
  bfp_flags_t        live;
  logic              oc_sample_ok;
  logic              force_low;
  logic              hot;

  assign pin_raw = {ext_prog_wr_req, ext_prog_rd_req, over_temp_in};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
    end
  end

  assign hot = sync2_r[0];

  bfp_leb_timer u_leb (
    .pclk      (pclk),
    .presetn   (presetn),
    .hs_on     (pwm_high_in),
    .leb_sel   (oc_ctrl_r.leb),
    .sample_ok (oc_sample_ok)
  );

  // apb slave: zero-wait, answer registered in the setup cycle and seen in the first access cycle
  // status reads live comparators, flags read the registered copy, sticky except vin
  always_comb begin
    setup       = psel & ~penable;
    access      = psel & penable & pready_r;
    wr          = access & pwrite;
    hit         = 1'b1;
    rd_val      = 32'h0000_0000;
    case (paddr)
      ADDR_VIN_LVL:  rd_val = 32'(vin_lvl_r);
      ADDR_OC_CTRL:  rd_val = 32'(oc_ctrl_r);
      ADDR_ABE:      rd_val = 32'(abe_r);
      ADDR_UV_THR:   rd_val = 32'(uv_thr_r);
      ADDR_OV_THR:   rd_val = 32'(ov_thr_r);
      ADDR_FLAGS:    rd_val = 32'(flags_r);
      ADDR_DRV_OPT:  rd_val = 32'(drv_opt_r);
      ADDR_DRV_TEST: rd_val = 32'(drv_test_r);
      ADDR_BUS_ADDR: rd_val = 32'(bus_addr_r);
      ADDR_ALERT:    rd_val = 32'(alert_addr_r);
      ADDR_IRQ_CTRL: rd_val = 32'(irq_ctrl_r);
      ADDR_STATUS:   rd_val = 32'(live);
      default:       hit    = 1'b0;
    endcase
    pready_nxt  = setup;
    prdata_nxt  = (setup & ~pwrite) ? rd_val : 32'h0000_0000;
    pslverr_nxt = setup & ~hit;
  end

  // software writes
  // a write lands only in the access cycle, never at setup
  always_comb begin
    vin_lvl_nxt    = vin_lvl_r;
    oc_ctrl_nxt    = oc_ctrl_r;
    abe_nxt        = abe_r;
    uv_thr_nxt     = uv_thr_r;
    ov_thr_nxt     = ov_thr_r;
    drv_opt_nxt    = drv_opt_r;
    drv_test_nxt   = drv_test_r;
    irq_ctrl_nxt   = irq_ctrl_r;
    bus_addr_nxt   = bus_addr_r;
    alert_addr_nxt = alert_addr_r;
    w1c            = '0;
    if (wr) begin
      case (paddr)
        ADDR_VIN_LVL:  vin_lvl_nxt    = pwdata[$bits(bfp_vin_lvl_t)-1:0];
        ADDR_OC_CTRL:  oc_ctrl_nxt    = pwdata[$bits(bfp_oc_ctrl_t)-1:0];
        ADDR_ABE:      abe_nxt        = pwdata[$bits(bfp_abe_t)-1:0];
        ADDR_UV_THR:   uv_thr_nxt     = pwdata[SENSE_W-1:0];
        ADDR_OV_THR:   ov_thr_nxt     = pwdata[SENSE_W-1:0];
        ADDR_FLAGS:    w1c            = pwdata[$bits(bfp_flags_t)-1:0];
        ADDR_DRV_OPT:  drv_opt_nxt    = pwdata[$bits(bfp_drv_opt_t)-1:0];
        ADDR_DRV_TEST: drv_test_nxt   = pwdata[$bits(bfp_drv_test_t)-1:0];
        ADDR_BUS_ADDR: bus_addr_nxt   = pwdata[ADDR_W-1:0]; // see RL16
        ADDR_ALERT:    alert_addr_nxt = pwdata[ADDR_W-1:0]; // see RL17
        ADDR_IRQ_CTRL: irq_ctrl_nxt   = pwdata[$bits(bfp_irq_ctrl_t)-1:0];
        default:       w1c            = '0;
      endcase
    end
  end

  // comparators stay idle until firmware sets each enable bit
  // oc flags only; firmware decides whether to stop switching
  // fault detection; enables in irq_ctrl never gate a flag
  always_comb begin
    live.vin = vin_lvl_r.en & (vin_code < vin_lvl_r.level); // see RL1
    live.oc  = oc_ctrl_r.en & oc_sample_ok & (hs_vds_code > oc_ctrl_r.thr); // see RL5
    live.uv  = abe_r.uv_en & (vout_code < uv_thr_r); // see RL8
    live.ov  = abe_r.ov_en & (vout_code > ov_thr_r); // see RL11
    live.ot  = hot; // see RL14
    set      = live; // see RL4
    flags_nxt     = (flags_r & ~w1c) | set; // set wins over a same-cycle clear
    flags_nxt.vin = live.vin; // see RL2
  end

  // gate drive forcing; one cycle of register latency from pwm to pin
  // hot is the synced level, so a blip shorter than a clock may slip by
  always_comb begin
    force_low = drv_test_r.drv_dis // see RL19
              | hot // see RL14
              | (drv_opt_r.uv_trip & flags_r.uv) // see RL10
              | (drv_opt_r.ov_trip & flags_r.ov); // see RL13
    high_gate_nxt   = pwm_high_in & ~force_low & ~drv_test_r.hi_dis; // see RL21 RL20
    low_gate_nxt    = pwm_low_in & ~force_low & ~drv_test_r.lo_dis; // see RL21 RL20
    phase_float_nxt = drv_test_r.drv_dis; // see RL19
    tsd_nxt         = hot;
    cp_nxt          = code_protect_bit;
    // strap taken through a register, never into the reset value
    prog_rd_nxt     = sync2_r[1] & ~cp_r; // see RL15
    prog_wr_nxt     = sync2_r[2] & ~cp_r; // see RL15
  end

  // reset leaves every gate low and code protection engaged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vin_lvl_r     <= '{en: 1'b0, level: LVL_RST};
      oc_ctrl_r     <= '{en: 1'b0, leb: 2'h0, thr: LVL_RST};
      abe_r         <= '0;
      uv_thr_r      <= LVL_RST;
      ov_thr_r      <= LVL_RST;
      flags_r       <= '0;
      drv_opt_r     <= '0;
      drv_test_r    <= '0;
      irq_ctrl_r    <= '0;
      bus_addr_r    <= BUS_ADDR_RST;
      alert_addr_r  <= ALERT_RST;
      prdata_r      <= 32'h0000_0000;
      pready_r      <= 1'b0;
      pslverr_r     <= 1'b0;
      high_gate_r   <= 1'b0;
      low_gate_r    <= 1'b0;
      phase_float_r <= 1'b0;
      tsd_r         <= 1'b0;
      prog_rd_r     <= 1'b0;
      prog_wr_r     <= 1'b0;
      cp_r          <= 1'b1;
    end else begin
      vin_lvl_r     <= vin_lvl_nxt;
      oc_ctrl_r     <= oc_ctrl_nxt;
      abe_r         <= abe_nxt;
      uv_thr_r      <= uv_thr_nxt;
      ov_thr_r      <= ov_thr_nxt;
      flags_r       <= flags_nxt;
      drv_opt_r     <= drv_opt_nxt;
      drv_test_r    <= drv_test_nxt;
      irq_ctrl_r    <= irq_ctrl_nxt;
      bus_addr_r    <= bus_addr_nxt;
      alert_addr_r  <= alert_addr_nxt;
      prdata_r      <= prdata_nxt;
      pready_r      <= pready_nxt;
      pslverr_r     <= pslverr_nxt;
      high_gate_r   <= high_gate_nxt;
      low_gate_r    <= low_gate_nxt;
      phase_float_r <= phase_float_nxt;
      tsd_r         <= tsd_nxt;
      prog_rd_r     <= prog_rd_nxt;
      prog_wr_r     <= prog_wr_nxt;
      cp_r          <= cp_nxt;
    end
  end

  // every output is a flop, so no glitch reaches a gate pin
  assign prdata              = prdata_r;
  assign pready              = pready_r;
  assign pslverr             = pslverr_r;
  assign high_gate_out       = high_gate_r;
  assign low_gate_out        = low_gate_r;
  assign phase_float         = phase_float_r;
  assign pull_up_setting     = drv_opt_r.pull_up;
  assign thermal_shutdown    = tsd_r;
  assign prog_rd_en          = prog_rd_r;
  assign prog_wr_en          = prog_wr_r;
  assign primary_bus_address = bus_addr_r;
  assign alert_address       = alert_addr_r;

endmodule // bfp_fault_top

// ===== verilog/bfp_leb_timer.sv
// leading-edge blanking timer for the high-side overcurrent sample window
`timescale 1ns/1ps
module bfp_leb_timer
  import bfp_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       hs_on,
  input  wire logic [1:0] leb_sel,
  output logic            sample_ok
);

  logic              hs_on_r;
  logic              hs_on_nxt;
  logic [LEB_CW-1:0] cnt_r;
  logic [LEB_CW-1:0] cnt_nxt;
  logic [LEB_CW-1:0] load_val;
  logic              rise;

  always_comb begin
    case (leb_sel)
      2'h0:    load_val = LEB_CYC_0;
      2'h1:    load_val = LEB_CYC_1;
      2'h2:    load_val = LEB_CYC_2;
      default: load_val = LEB_CYC_3;
    endcase
    rise      = hs_on & ~hs_on_r;
    hs_on_nxt = hs_on;
    cnt_nxt   = cnt_r;
    if (rise) begin
      cnt_nxt = load_val; // see RL6
    end else if (!hs_on) begin
      cnt_nxt = '0;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - LEB_CW'(1);
    end
    // blanked on the turn-on edge and until the count runs out
    sample_ok = hs_on & ~rise & (cnt_r == '0); // see RL6
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_on_r <= 1'b0;
      cnt_r   <= '0;
    end else begin
      hs_on_r <= hs_on_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

endmodule // bfp_leb_timer

// ===== verilog/bfp_pkg.sv
// package: register map, field layouts and timing for the buck fault protection block
package bfp_pkg;

  localparam int          APB_AW        = 8;
  localparam int          SENSE_W       = 8;
  localparam int          ADDR_W        = 7;

  localparam logic [7:0]  ADDR_VIN_LVL  = 8'h00;
  localparam logic [7:0]  ADDR_OC_CTRL  = 8'h04;
  localparam logic [7:0]  ADDR_ABE      = 8'h08;
  localparam logic [7:0]  ADDR_UV_THR   = 8'h0C;
  localparam logic [7:0]  ADDR_OV_THR   = 8'h10;
  localparam logic [7:0]  ADDR_FLAGS    = 8'h14;
  localparam logic [7:0]  ADDR_DRV_OPT  = 8'h18;
  localparam logic [7:0]  ADDR_DRV_TEST = 8'h1C;
  localparam logic [7:0]  ADDR_BUS_ADDR = 8'h20;
  localparam logic [7:0]  ADDR_ALERT    = 8'h24;
  localparam logic [7:0]  ADDR_IRQ_CTRL = 8'h28;
  localparam logic [7:0]  ADDR_STATUS   = 8'h2C;

  // input undervoltage level: bit 8 enable, bits 7:0 level
  typedef struct packed {
    logic               en;
    logic [SENSE_W-1:0] level;
  } bfp_vin_lvl_t;

  // overcurrent control: bit 10 enable, bits 9:8 blanking select, bits 7:0 threshold
  typedef struct packed {
    logic               en;
    logic [1:0]         leb;
    logic [SENSE_W-1:0] thr;
  } bfp_oc_ctrl_t;

  typedef struct packed {
    logic ov_en;
    logic uv_en;
  } bfp_abe_t;

  typedef struct packed {
    logic ot;
    logic ov;
    logic uv;
    logic oc;
    logic vin;
  } bfp_flags_t;

  typedef struct packed {
    logic pull_up;
    logic ov_trip;
    logic uv_trip;
  } bfp_drv_opt_t;

  typedef struct packed {
    logic lo_dis;
    logic hi_dis;
    logic drv_dis;
  } bfp_drv_test_t;

  typedef struct packed {
    logic       global_irq_enable;
    bfp_flags_t en;
  } bfp_irq_ctrl_t;

  localparam logic [SENSE_W-1:0] LVL_RST      = 8'h00;
  localparam logic [ADDR_W-1:0]  BUS_ADDR_RST = 7'h00;
  localparam logic [ADDR_W-1:0]  ALERT_RST    = 7'h0C;

  // leading-edge blanking lengths per select code
  localparam int CLK_NS    = 8;
  localparam int LEB_NS_0  = 40;
  localparam int LEB_NS_1  = 80;
  localparam int LEB_NS_2  = 120;
  localparam int LEB_NS_3  = 160;
  localparam int LEB_CW    = 5;
  localparam logic [LEB_CW-1:0] LEB_CYC_0 = LEB_CW'((LEB_NS_0 + CLK_NS - 1) / CLK_NS);
  localparam logic [LEB_CW-1:0] LEB_CYC_1 = LEB_CW'((LEB_NS_1 + CLK_NS - 1) / CLK_NS);
  localparam logic [LEB_CW-1:0] LEB_CYC_2 = LEB_CW'((LEB_NS_2 + CLK_NS - 1) / CLK_NS);
  localparam logic [LEB_CW-1:0] LEB_CYC_3 = LEB_CW'((LEB_NS_3 + CLK_NS - 1) / CLK_NS);

endpackage
